// ---- logic/mmd_pkg.sv ----
package mmd_pkg;

    localparam int          ADDR_W       = 16;
    localparam int          ALLOC_W      = 8;

    typedef enum logic [3:0] {
        RG_EXT    = 4'h0,
        RG_MMR    = 4'h1,
        RG_BLK0   = 4'h2,
        RG_BLK1   = 4'h3,
        RG_BLK2   = 4'h4,
        RG_SINGLE = 4'h5,
        RG_ROM    = 4'h6,
        RG_BOOT   = 4'h7,
        RG_IOREG  = 4'h8,
        RG_RSVD   = 4'h9,
        RG_GLOBAL = 4'ha
    } mmd_region_e;

    typedef enum logic [1:0] {
        SP_PROG = 2'h0,
        SP_DATA = 2'h1,
        SP_IO   = 2'h2
    } mmd_space_e;

    // data space
    localparam logic [15:0] MMR_LO       = 16'h0000;
    localparam logic [15:0] MMR_HI       = 16'h005f;
    localparam logic [15:0] BLK2_LO      = 16'h0060;
    localparam logic [15:0] BLK2_HI      = 16'h007f;
    localparam logic [15:0] BLK0D_LO     = 16'h0100;
    localparam logic [15:0] BLK0D_HI     = 16'h02ff;
    localparam logic [15:0] BLK1_LO      = 16'h0300;
    localparam logic [15:0] BLK1_HI      = 16'h04ff;
    localparam logic [15:0] LOW_RSVD_HI  = 16'h07ff;
    localparam logic [15:0] MID_LO       = 16'h0800;
    localparam logic [15:0] MID_HI       = 16'h0fff;
    localparam logic [15:0] SINGLE_LO    = 16'h1000;
    localparam logic [15:0] SINGLE_HI    = 16'h1fff;
    localparam int          SINGLE_BLK_BIT = 11;
    // program space
    localparam logic [15:0] ROM_LO       = 16'h0000;
    localparam logic [15:0] ROM_HI       = 16'h0fff;
    localparam logic [15:0] BOOT_HI      = 16'h00ff;
    localparam logic [15:0] BLK0P_LO     = 16'hfe00;
    localparam logic [15:0] BLK0P_HI     = 16'hffff;
    // i/o space
    localparam logic [15:0] IO_ROMV_LO   = 16'hfff0;
    localparam logic [15:0] IO_BOOTV_LO  = 16'hffe0;
    localparam logic [15:0] IO_HI        = 16'hffff;

    // reset values
    localparam logic [7:0]  ALLOC_RST    = 8'h00;
    localparam logic        ROM_SEL_RST  = 1'b1;
    localparam logic        RAM_STRAP_RST = 1'b0;
    localparam logic        BOOT_RST     = 1'b1;
    localparam logic [1:0]  STRAP_SETTLE = 2'h2;

    function automatic logic in_rng(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic is_global(input logic [15:0] a, input logic [7:0] alloc);
        return (alloc != 8'h00) && ((a[15:8] & alloc) == alloc);
    endfunction

endpackage

// ---- logic/mmd_cfg_if.sv ----
`timescale 1ns/1ps
interface mmd_cfg_if;
    logic       blk0_prog;
    logic       rom_en;
    logic       ram_en;
    logic       boot_en;
    logic [7:0] alloc;

    modport src (output blk0_prog, output rom_en, output ram_en, output boot_en, output alloc);
    modport dec (input blk0_prog, input rom_en, input ram_en, input boot_en, input alloc);
endinterface

// ---- logic/mmd_space_decode.sv ----
`timescale 1ns/1ps
module mmd_space_decode #(
    parameter mmd_pkg::mmd_space_e SPACE       = mmd_pkg::SP_DATA,
    parameter bit                  ROM_VARIANT = 1'b1
) (
    // configuration
    mmd_cfg_if.dec                 cfg,
    // address
    input  wire logic [15:0]       addr,
    // result
    output mmd_pkg::mmd_region_e   region
);
    mmd_pkg::mmd_region_e prog_rg;
    mmd_pkg::mmd_region_e data_rg;
    mmd_pkg::mmd_region_e io_rg;

    wire        sa_on   = ROM_VARIANT && cfg.ram_en;
    wire        in_sa   = mmd_pkg::in_rng(addr, mmd_pkg::SINGLE_LO, mmd_pkg::SINGLE_HI);
    wire [15:0] io_lo   = ROM_VARIANT ? mmd_pkg::IO_ROMV_LO : mmd_pkg::IO_BOOTV_LO;
    wire        in_mid  = mmd_pkg::in_rng(addr, mmd_pkg::MID_LO, mmd_pkg::MID_HI);

    // glob checked last: on-chip claims the low 2K first
    assign data_rg =
        mmd_pkg::in_rng(addr, mmd_pkg::MMR_LO, mmd_pkg::MMR_HI) ? mmd_pkg::RG_MMR :  // RL4 RL17
        mmd_pkg::in_rng(addr, mmd_pkg::BLK2_LO, mmd_pkg::BLK2_HI)   ? mmd_pkg::RG_BLK2 : // RL10
        mmd_pkg::in_rng(addr, mmd_pkg::BLK0D_LO, mmd_pkg::BLK0D_HI) ?
            (cfg.blk0_prog ? mmd_pkg::RG_RSVD : mmd_pkg::RG_BLK0) :                 // RL11 RL12
        mmd_pkg::in_rng(addr, mmd_pkg::BLK1_LO, mmd_pkg::BLK1_HI)   ? mmd_pkg::RG_BLK1 : // RL12
        (addr <= mmd_pkg::LOW_RSVD_HI)                              ? mmd_pkg::RG_RSVD :
        (in_mid && sa_on)                                           ? mmd_pkg::RG_RSVD :
        (in_sa && sa_on)                                            ? mmd_pkg::RG_SINGLE : // RL8
        mmd_pkg::is_global(addr, cfg.alloc)                         ? mmd_pkg::RG_GLOBAL : // RL2
        mmd_pkg::RG_EXT;                                                               // RL20

    assign prog_rg =
        (ROM_VARIANT && cfg.rom_en &&
         mmd_pkg::in_rng(addr, mmd_pkg::ROM_LO, mmd_pkg::ROM_HI)) ? mmd_pkg::RG_ROM :  // RL5 RL6
        (!ROM_VARIANT && cfg.boot_en && (addr <= mmd_pkg::BOOT_HI)) ? mmd_pkg::RG_BOOT :
        (in_sa && sa_on)                                          ? mmd_pkg::RG_SINGLE : // RL8
        (cfg.blk0_prog && mmd_pkg::in_rng(addr, mmd_pkg::BLK0P_LO, mmd_pkg::BLK0P_HI)) ?
            mmd_pkg::RG_BLK0 :                                                          // RL11 RL12
        mmd_pkg::RG_EXT;                                                                // RL20

    assign io_rg = mmd_pkg::in_rng(addr, io_lo, mmd_pkg::IO_HI) ?
                   mmd_pkg::RG_IOREG : mmd_pkg::RG_EXT;                // RL13 RL18 RL17 RL20

    assign region = (SPACE == mmd_pkg::SP_PROG) ? prog_rg :
                    (SPACE == mmd_pkg::SP_DATA) ? data_rg : io_rg;     // RL1
endmodule // mmd_space_decode

// ---- logic/mmd_memory_map_decoder.sv ----
`timescale 1ns/1ps
// How it works
// RL1: program, data and i/o are separate 64K-word spaces, 16-bit words.
// RL2: top of data space is global memory, size from the allocation register.
// RL3: global data accesses raise the global bus request.
// RL4: data addresses 0 to 5f decode as mapped registers, not ram.
// RL5: rom variant samples the rom strap at reset; off means external.
// RL6: rom is 4K words at program 0, mapped only while strap is low.
// RL7: single-access ram is 2K blocks; same-block double access is flagged.
// RL8: 4K single-access ram at 1000 in both spaces only with ram strap high.
// RL9: dual-access ram takes a read and a write in one cycle freely.
// RL10: dual block one is 512 words, block two 32 words at data 60.
// RL11: block zero sits in data when select is clear, program when set.
// RL12: block zero decodes at data 100 to 2ff or program fe00 to ffff, block one at data 300 to 4ff; block two decodes only at data 60 to 7f.
// RL13: bootloader variant decodes i/o ffe0 upward on chip.
// RL14: i/o ff00 to ff0f is for factory test; others must not use it.
// RL15: on-chip access has no wait; external waits on the ready pin.
// RL16: three concurrent accesses per cycle are supported without stalls.
// RL17: mapped registers live in internal data and i/o space.
// RL18: rom variant decodes i/o fff0 upward on chip.
// RL19: allocation register clears at reset, leaving no global region.
// RL20: anything unclaimed goes to the external interface of its space.
// RL21: straps are latched after reset and held until the next reset.
module mmd_memory_map_decoder #(
    parameter bit ROM_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // strap pins
    input  wire logic                 rom_select_strap,
    input  wire logic                 single_access_ram_enable_strap,
    input  wire logic                 boot_strap,
    // software configuration
    input  wire logic                 block_zero_space_select,
    input  wire logic                 global_alloc_wr,
    input  wire logic [7:0]           global_alloc_wdata,
    // access requests
    input  wire logic                 prog_valid,
    input  wire logic [15:0]          prog_addr,
    input  wire logic                 drd_valid,
    input  wire logic [15:0]          drd_addr,
    input  wire logic                 dwr_valid,
    input  wire logic [15:0]          dwr_addr,
    input  wire logic                 io_valid,
    input  wire logic [15:0]          io_addr,
    // external ready pin
    input  wire logic                 ext_ready,
    // steering results
    output mmd_pkg::mmd_region_e      prog_region,
    output mmd_pkg::mmd_region_e      drd_region,
    output mmd_pkg::mmd_region_e      dwr_region,
    output mmd_pkg::mmd_region_e      io_region,
    output logic                      prog_ext_req,
    output logic                      drd_ext_req,
    output logic                      dwr_ext_req,
    output logic                      io_ext_req,
    // status
    output logic                      global_bus_request,
    output logic                      single_access_ram_conflict,
    output logic                      access_ready,
    output logic [7:0]                global_alloc_reg
);
    mmd_cfg_if cfg ();

    logic [2:0]             strap_s1_reg;
    logic [2:0]             strap_s2_reg;
    logic [1:0]             settle_reg;
    logic                   rom_sel_reg;
    logic                   ram_on_reg;
    logic                   boot_reg;
    logic                   rdy_s1_reg;
    logic                   rdy_s2_reg;
    logic [7:0]             alloc_reg;
    logic [3:0]             ext_req_reg;
    logic                   gbr_reg;
    logic                   conflict_reg;
    logic                   ready_reg;
    mmd_pkg::mmd_region_e   region_reg [4];
    mmd_pkg::mmd_region_e   region_raw [4];
    logic [15:0]            addr_a     [4];
    logic [3:0]             valid_a;
    logic [3:0]             ext_next;

    assign addr_a[0] = prog_addr;
    assign addr_a[1] = drd_addr;
    assign addr_a[2] = dwr_addr;
    assign addr_a[3] = io_addr;
    assign valid_a   = {io_valid, dwr_valid, drd_valid, prog_valid};

    // rom strap active low, boot strap active low
    assign cfg.blk0_prog = block_zero_space_select;
    assign cfg.rom_en    = !rom_sel_reg;
    assign cfg.ram_en    = ram_on_reg;
    assign cfg.boot_en   = !boot_reg;
    assign cfg.alloc     = alloc_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_dec
            mmd_space_decode #(
                .SPACE       ((gi == 0) ? mmd_pkg::SP_PROG :
                              (gi == 3) ? mmd_pkg::SP_IO : mmd_pkg::SP_DATA),
                .ROM_VARIANT (ROM_VARIANT)
            ) u_dec (
                .cfg    (cfg),
                .addr   (addr_a[gi]),
                .region (region_raw[gi])
            );
            assign ext_next[gi] = valid_a[gi] &&
                                  ((region_raw[gi] == mmd_pkg::RG_EXT) ||
                                   (region_raw[gi] == mmd_pkg::RG_GLOBAL));  // RL20
        end
    endgenerate

    wire sa_p  = prog_valid && (region_raw[0] == mmd_pkg::RG_SINGLE);
    wire sa_r  = drd_valid  && (region_raw[1] == mmd_pkg::RG_SINGLE);
    wire sa_w  = dwr_valid  && (region_raw[2] == mmd_pkg::RG_SINGLE);
    wire bk_p  = prog_addr[mmd_pkg::SINGLE_BLK_BIT];
    wire bk_r  = drd_addr[mmd_pkg::SINGLE_BLK_BIT];
    wire bk_w  = dwr_addr[mmd_pkg::SINGLE_BLK_BIT];
    // dual-access hits never count here, so they never clash
    wire clash = (sa_p && sa_r && (bk_p == bk_r)) ||
                 (sa_p && sa_w && (bk_p == bk_w)) ||
                 (sa_r && sa_w && (bk_r == bk_w));                          // RL7 RL9
    wire gbr_next = (drd_valid && (region_raw[1] == mmd_pkg::RG_GLOBAL)) ||
                    (dwr_valid && (region_raw[2] == mmd_pkg::RG_GLOBAL));   // RL3
    // on-chip accesses complete at once; any external one waits for ready
    wire ready_next = (ext_next == 4'h0) || rdy_s2_reg;                     // RL15 RL16
    wire latch_now  = (settle_reg == mmd_pkg::STRAP_SETTLE);

    // straps pass two flops, then are caught once after reset release
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            strap_s1_reg <= 3'h0;
            strap_s2_reg <= 3'h0;
            settle_reg   <= 2'h0;
            rom_sel_reg  <= mmd_pkg::ROM_SEL_RST;
            ram_on_reg   <= mmd_pkg::RAM_STRAP_RST;
            boot_reg     <= mmd_pkg::BOOT_RST;
        end
        else
        begin
            strap_s1_reg <= {boot_strap, single_access_ram_enable_strap, rom_select_strap};
            strap_s2_reg <= strap_s1_reg;
            // stop counting at 2: a wrap would re-latch the straps every few cycles
            if (settle_reg < mmd_pkg::STRAP_SETTLE)
                settle_reg <= settle_reg + 2'h1;
            if (latch_now && (settle_reg != 2'h3))
            begin
                rom_sel_reg <= strap_s2_reg[0];  // RL5 RL21
                ram_on_reg  <= strap_s2_reg[1];  // RL21
                boot_reg    <= strap_s2_reg[2];  // RL21
                settle_reg  <= 2'h3;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rdy_s1_reg   <= 1'b0;
            rdy_s2_reg   <= 1'b0;
            alloc_reg    <= mmd_pkg::ALLOC_RST;  // RL19
            ext_req_reg  <= 4'h0;
            gbr_reg      <= 1'b0;
            conflict_reg <= 1'b0;
            ready_reg    <= 1'b1;
            for (int i = 0; i < 4; i++)
                region_reg[i] <= mmd_pkg::RG_EXT;
        end
        else
        begin
            rdy_s1_reg   <= ext_ready;
            rdy_s2_reg   <= rdy_s1_reg;
            if (global_alloc_wr)
                alloc_reg <= global_alloc_wdata;  // RL2
            ext_req_reg  <= ext_next;
            gbr_reg      <= gbr_next;
            conflict_reg <= clash;
            ready_reg    <= ready_next;
            for (int i = 0; i < 4; i++)
                region_reg[i] <= valid_a[i] ? region_raw[i] : mmd_pkg::RG_EXT;
        end
    end

    // the settle code 3 means latched; the latch branch above runs once
    assign prog_region        = region_reg[0];
    assign drd_region         = region_reg[1];
    assign dwr_region         = region_reg[2];
    assign io_region          = region_reg[3];
    assign prog_ext_req       = ext_req_reg[0];
    assign drd_ext_req        = ext_req_reg[1];
    assign dwr_ext_req        = ext_req_reg[2];
    assign io_ext_req         = ext_req_reg[3];
    assign global_bus_request = gbr_reg;
    assign single_access_ram_conflict     = conflict_reg;
    assign access_ready       = ready_reg;
    assign global_alloc_reg   = alloc_reg;

    mmr_decode_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
        drd_valid && (drd_addr <= mmd_pkg::MMR_HI) |=> drd_region == mmd_pkg::RG_MMR)
        else $error("low data address not decoded as register");
    blk2_place_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL10
        drd_valid && mmd_pkg::in_rng(drd_addr, mmd_pkg::BLK2_LO, mmd_pkg::BLK2_HI)
        |=> drd_region == mmd_pkg::RG_BLK2)
        else $error("block two not at 60");
    blk0_data_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL11
        dwr_valid && !block_zero_space_select
        && mmd_pkg::in_rng(dwr_addr, mmd_pkg::BLK0D_LO, mmd_pkg::BLK0D_HI)
        |=> dwr_region == mmd_pkg::RG_BLK0)
        else $error("block zero missing in data space");
    blk0_prog_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL12
        prog_valid && block_zero_space_select && (prog_addr[15:9] == 7'h7f)
        |=> prog_region == mmd_pkg::RG_BLK0 && !prog_ext_req)
        else $error("block zero alias missing in program space");
    alloc_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL19
        $rose(resetn) |-> global_alloc_reg == mmd_pkg::ALLOC_RST && !global_bus_request)
        else $error("allocation register not cleared by reset");
    strap_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL21
        (settle_reg == 2'h3) && $past(settle_reg == 2'h3)
        |-> $stable(rom_sel_reg) && $stable(ram_on_reg) && $stable(boot_reg))
        else $error("strap changed after latching");
    wait_free_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL15
        (ext_next == 4'h0) |=> access_ready ##0 (ext_req_reg == 4'h0))
        else $error("on-chip access given a wait");
    global_req_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL3
        global_bus_request |-> $past(drd_valid || dwr_valid)
        && ((drd_region == mmd_pkg::RG_GLOBAL) || (dwr_region == mmd_pkg::RG_GLOBAL)))
        else $error("global request without global access");
    clash_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL7
        single_access_ram_conflict |-> $past(clash) && ($past(sa_p) + $past(sa_r) + $past(sa_w) >= 2))
        else $error("conflict flagged without same-block access");
    io_int_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL18
        io_valid && (io_addr >= mmd_pkg::IO_ROMV_LO)
        |=> io_region == mmd_pkg::RG_IOREG && !io_ext_req)
        else $error("internal i/o sent off chip");
endmodule // mmd_memory_map_decoder

// ---- sim/mmd_ext_mem_model.sv ----
`timescale 1ns/1ps
module mmd_ext_mem_model (
    // clock
    input  wire logic       sys_clk,
    // any external request from the decoder
    input  wire logic       ext_busy,
    // wait length chosen by the bench
    input  wire logic [3:0] wait_len,
    // ready pin
    output logic            ext_ready
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // saturate so a long hold never wraps back into a wait
    assign cnt_next = (cnt_reg == 4'hf) ? cnt_reg : cnt_reg + 4'h1;

    always_ff @(posedge sys_clk)
    begin
        cnt_reg <= ext_busy ? cnt_next : 4'h0;
    end

    // ready idles high like a pulled-up pin; slow memory holds it low
    assign ext_ready = !ext_busy || (cnt_reg >= wait_len);
endmodule // mmd_ext_mem_model

// ---- sim/tb_memory_map_decoder.sv ----
`timescale 1ns/1ps
module tb_memory_map_decoder;
    logic                 sys_clk  = 1'b0;
    logic                 resetn   = 1'b0;
    logic                 rom_s    = 1'b1;
    logic                 ram_s    = 1'b0;
    logic                 boot_s   = 1'b1;
    logic                 bzs      = 1'b0;
    logic                 gwr      = 1'b0;
    logic [7:0]           gwd      = 8'h00;
    logic                 pv       = 1'b0;
    logic                 dv       = 1'b0;
    logic                 wv       = 1'b0;
    logic                 iv       = 1'b0;
    logic [15:0]          pa       = 16'h0000;
    logic [15:0]          da       = 16'h0000;
    logic [15:0]          wa       = 16'h0000;
    logic [15:0]          ia       = 16'h0000;
    logic [3:0]           wait_len = 4'h0;
    logic                 ext_ready;
    mmd_pkg::mmd_region_e pr;
    mmd_pkg::mmd_region_e dr;
    mmd_pkg::mmd_region_e wr;
    mmd_pkg::mmd_region_e ir;
    mmd_pkg::mmd_region_e bpr;
    logic                 pe;
    logic                 de;
    logic                 we;
    logic                 ie;
    logic                 bie;
    logic                 gbr;
    logic                 conf;
    logic                 ardy;
    logic [7:0]           galloc;
    int                   fail_count = 0;
    int                   cmp_count  = 0;
    int                   lows;

    always #50 sys_clk = ~sys_clk;

    mmd_memory_map_decoder #(.ROM_VARIANT(1'b1)) i_mmd_memory_map_decoder (
        .sys_clk(sys_clk), .resetn(resetn), .rom_select_strap(rom_s),
        .single_access_ram_enable_strap(ram_s), .boot_strap(boot_s), .block_zero_space_select(bzs),
        .global_alloc_wr(gwr), .global_alloc_wdata(gwd), .prog_valid(pv), .prog_addr(pa),
        .drd_valid(dv), .drd_addr(da), .dwr_valid(wv), .dwr_addr(wa), .io_valid(iv),
        .io_addr(ia), .ext_ready(ext_ready), .prog_region(pr), .drd_region(dr),
        .dwr_region(wr), .io_region(ir), .prog_ext_req(pe), .drd_ext_req(de),
        .dwr_ext_req(we), .io_ext_req(ie), .global_bus_request(gbr), .single_access_ram_conflict(conf),
        .access_ready(ardy), .global_alloc_reg(galloc));

    // second variant shares every input; only its program and i/o steering is judged
    mmd_memory_map_decoder #(.ROM_VARIANT(1'b0)) i_mmd_memory_map_decoder_boot (
        .sys_clk(sys_clk), .resetn(resetn), .rom_select_strap(rom_s),
        .single_access_ram_enable_strap(ram_s), .boot_strap(boot_s), .block_zero_space_select(bzs),
        .global_alloc_wr(gwr), .global_alloc_wdata(gwd), .prog_valid(pv), .prog_addr(pa),
        .drd_valid(dv), .drd_addr(da), .dwr_valid(wv), .dwr_addr(wa), .io_valid(iv),
        .io_addr(ia), .ext_ready(ext_ready), .prog_region(bpr), .drd_region(),
        .dwr_region(), .io_region(), .prog_ext_req(), .drd_ext_req(), .dwr_ext_req(),
        .io_ext_req(bie), .global_bus_request(), .single_access_ram_conflict(), .access_ready(),
        .global_alloc_reg());

    mmd_ext_mem_model i_mmd_ext_mem_model (
        .sys_clk(sys_clk), .ext_busy(pe | de | we | ie), .wait_len(wait_len),
        .ext_ready(ext_ready));

    function automatic logic [15:0] z(input mmd_pkg::mmd_region_e r);
        return {12'h000, r};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic regs(input mmd_pkg::mmd_region_e ep, ed, ew);
        check("prog_region", z(pr), z(ep));
        check("drd_region", z(dr), z(ed));
        check("dwr_region", z(wr), z(ew));
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // straps only count once latched, so wait well past the settle flops
    task automatic rst(input logic rom, ram, boot);
        @(posedge sys_clk);
        resetn <= 1'b0;
        {rom_s, ram_s, boot_s} <= {rom, ram, boot};
        {pv, dv, wv, iv, bzs} <= 5'h00;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    // answer is registered on the same edge that samples the request
    task automatic acc(input logic [15:0] p, d, w, i);
        @(posedge sys_clk);
        {pv, dv, wv, iv} <= 4'hf;
        {pa, da, wa, ia} <= {p, d, w, i};
        @(posedge sys_clk);
        #1;
    endtask

    task automatic gw(input logic [7:0] v);
        @(posedge sys_clk);
        {gwr, gwd} <= {1'b1, v};
        @(posedge sys_clk);
        gwr <= 1'b0;
        #1;
        check("global_alloc_reg", {8'h00, galloc}, {8'h00, v});
    endtask

    task automatic s_reset();
        rst(1'b1, 1'b0, 1'b1);
        check("global_alloc_reg", {8'h00, galloc}, 16'h0000);
        check("access_ready", {15'h0, ardy}, 16'h0001);
        regs(mmd_pkg::RG_EXT, mmd_pkg::RG_EXT, mmd_pkg::RG_EXT);
    endtask

    // io ff00-ff0f is kept for factory test and never addressed here
    task automatic s_rom_map();
        rst(1'b0, 1'b1, 1'b1);
        @(posedge sys_clk);
        rom_s <= 1'b1;
        acc(16'h0000, 16'h0005, 16'h0065, 16'hfff0);
        regs(mmd_pkg::RG_ROM, mmd_pkg::RG_MMR, mmd_pkg::RG_BLK2);
        check("io_ext_req", {15'h0, ie}, 16'h0000);
        check("io_region", z(ir), z(mmd_pkg::RG_IOREG));
        acc(16'h1000, 16'h0100, 16'h0200, 16'hffef);
        regs(mmd_pkg::RG_SINGLE, mmd_pkg::RG_BLK0, mmd_pkg::RG_BLK0);
        check("io_ext_req", {15'h0, ie}, 16'h0001);
        check("io_region", z(ir), z(mmd_pkg::RG_EXT));
        acc(16'hfe00, 16'h0300, 16'h0400, 16'hff10);
        regs(mmd_pkg::RG_EXT, mmd_pkg::RG_BLK1, mmd_pkg::RG_BLK1);
        check("prog_ext_req", {15'h0, pe}, 16'h0001);
        acc(16'h0fff, 16'h0800, 16'h1fff, 16'h0000);
        regs(mmd_pkg::RG_ROM, mmd_pkg::RG_RSVD, mmd_pkg::RG_SINGLE);
        acc(16'h2000, 16'h005f, 16'h2000, 16'hfff0);
        regs(mmd_pkg::RG_EXT, mmd_pkg::RG_MMR, mmd_pkg::RG_EXT);
        @(posedge sys_clk);
        bzs <= 1'b1;
        acc(16'hfe00, 16'h0100, 16'h0060, 16'hfff0);
        regs(mmd_pkg::RG_BLK0, mmd_pkg::RG_RSVD, mmd_pkg::RG_BLK2);
        acc(16'hff00, 16'h0200, 16'h04ff, 16'hfff0);
        regs(mmd_pkg::RG_BLK0, mmd_pkg::RG_RSVD, mmd_pkg::RG_BLK1);
    endtask

    task automatic s_straps_off();
        rst(1'b1, 1'b0, 1'b1);
        acc(16'h0000, 16'h1000, 16'h0800, 16'hfff0);
        regs(mmd_pkg::RG_EXT, mmd_pkg::RG_EXT, mmd_pkg::RG_EXT);
        acc(16'h1000, 16'h07ff, 16'h1800, 16'hfff0);
        regs(mmd_pkg::RG_EXT, mmd_pkg::RG_RSVD, mmd_pkg::RG_EXT);
    endtask

    task automatic s_concurrent();
        rst(1'b0, 1'b1, 1'b1);
        acc(16'h0000, 16'h1000, 16'h17ff, 16'hfff0);
        check("single_access_ram_conflict", {15'h0, conf}, 16'h0001);
        acc(16'h0000, 16'h1000, 16'h1800, 16'hfff0);
        check("single_access_ram_conflict", {15'h0, conf}, 16'h0000);
        acc(16'h0000, 16'h0300, 16'h0300, 16'hfff0);
        check("single_access_ram_conflict", {15'h0, conf}, 16'h0000);
        check("access_ready", {15'h0, ardy}, 16'h0001);
    endtask

    task automatic s_global();
        gw(8'h80);
        acc(16'h0000, 16'h8000, 16'hff00, 16'hfff0);
        regs(mmd_pkg::RG_ROM, mmd_pkg::RG_GLOBAL, mmd_pkg::RG_GLOBAL);
        check("dwr_ext_req", {15'h0, we}, 16'h0001);
        check("global_bus_request", {15'h0, gbr}, 16'h0001);
        gw(8'hff);
        acc(16'h0000, 16'hfe00, 16'hff00, 16'hfff0);
        regs(mmd_pkg::RG_ROM, mmd_pkg::RG_EXT, mmd_pkg::RG_GLOBAL);
        acc(16'h0000, 16'hfe00, 16'h2000, 16'hfff0);
        check("global_bus_request", {15'h0, gbr}, 16'h0000);
        rst(1'b0, 1'b1, 1'b1);
        check("global_alloc_reg", {8'h00, galloc}, 16'h0000);
        acc(16'h0000, 16'hffff, 16'hff00, 16'hfff0);
        regs(mmd_pkg::RG_ROM, mmd_pkg::RG_EXT, mmd_pkg::RG_EXT);
    endtask

    task automatic s_ready();
        wait_len <= 4'h5;
        acc(16'h0000, 16'h2000, 16'h0300, 16'hfff0);
        check("drd_ext_req", {15'h0, de}, 16'h0001);
        lows = 0;
        repeat (20)
        begin
            @(posedge sys_clk);
            #1;
            lows += (ardy === 1'b0) ? 1 : 0;
        end
        check("access_ready low cycles", {15'h0, lows != 0}, 16'h0001);
        check("access_ready", {15'h0, ardy}, 16'h0001);
        acc(16'h0000, 16'h0300, 16'h0060, 16'hfff0);
        repeat (4) @(posedge sys_clk);
        #1;
        check("access_ready", {15'h0, ardy}, 16'h0001);
    endtask

    task automatic s_boot();
        rst(1'b1, 1'b1, 1'b0);
        acc(16'h0000, 16'h0005, 16'h0060, 16'hffe0);
        check("boot prog_region", z(bpr), z(mmd_pkg::RG_BOOT));
        check("boot io_ext_req", {15'h0, bie}, 16'h0000);
        check("io_ext_req", {15'h0, ie}, 16'h0001);
        acc(16'h1000, 16'h0005, 16'h0060, 16'hffdf);
        check("boot prog_region", z(bpr), z(mmd_pkg::RG_EXT));
        check("boot io_ext_req", {15'h0, bie}, 16'h0001);
        rst(1'b1, 1'b1, 1'b1);
        acc(16'h0000, 16'h0005, 16'h0060, 16'hffe0);
        check("boot prog_region", z(bpr), z(mmd_pkg::RG_EXT));
    endtask

    initial
    begin
        #(3000 * 100);
        fail_count++;
        $display("[ERR] watchdog expected finish seen timeout");
        end_sim();
    end

    initial
    begin
        s_reset();
        s_rom_map();
        s_straps_off();
        s_concurrent();
        s_global();
        s_ready();
        s_boot();
        end_sim();
    end
endmodule // tb_memory_map_decoder
